// *** sisp_top.sv ***
// Notes on behaviour
// RULE1: programming accepted over the serial pins only while reset pin is low.
// RULE2: enable instruction first; no write or erase runs before it.
// RULE3: eeprom write is self-timed and erases the byte before writing.
// RULE4: chip erase fills flash and eeprom with all ones.
// RULE5: flash word and eeprom byte addresses are separate spaces.
// RULE6: programmer keeps each clock phase longer than two main clocks.
// RULE7: incoming bits sampled on serial clock rising edge.
// RULE8: outgoing bits shifted out on serial clock falling edge.
// RULE9: programmer holds reset and clock low at power-up, or pulses reset.
// RULE10: programmer waits 20 ms before the enable instruction; the bench waits 100 main clocks after reset release.
// RULE11: second enable byte echoed while third byte shifts in.
// RULE12: programmer always sends all four enable bytes.
// RULE13: programmer retries with one extra clock pulse, up to 32 times.
// RULE14: programmer waits erase delay, pulses reset, then re-enables.
// RULE15: each write programs one byte, address and data from that instruction.
// RULE16: without polling, programmer waits write delay between writes.
// RULE17: read returns current content of addressed location.
// RULE18: reset pin going high leaves programming mode.
// RULE19: eeprom poll reads zero while erasing, then ones, then new value.
// RULE20: programmer waits write delay when data equals a poll value.
// RULE21: flash poll reads ones until the new byte is in.
// RULE22: writing ones to flash needs a full write delay wait.
// RULE23: skipping all-ones bytes only valid after chip erase.
// RULE24: enable is 0xAC then 0x53, accepted only with reset low.
// RULE25: 0xAC with byte two top bits 100 is chip erase.
// RULE26: 0xC0 is eeprom write; address from bytes two and three, data byte four.
// RULE27: 0x58 reads lock and fuse bits in byte four, zero is programmed.
// RULE28: frames are 32 bits, msb first, output aligned to input bytes.
// RULE29: delays counted on main clock; writes while busy are ignored.
`timescale 1ns/100ps
`include "sisp_cfg.svh"
module sisp_top import sisp_pkg::*; #(
    parameter int unsigned WR_CYC = `SISP_WR_MS*`SISP_US_MS*`SISP_CLK_MHZ,
    parameter int unsigned ER_CYC = `SISP_ER_MS*`SISP_US_MS*`SISP_CLK_MHZ,
    // arbitrary signature value
    parameter logic [23:0] SIG_BYTES = 24'h5A3C69,
    parameter logic        SPIEN_P   = 1'b0,
    parameter logic        FSTRT_P   = 1'b1
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin_rst_n,
    input  wire logic sck,
    input  wire logic mosi,
    output logic      miso,
    output logic      prog_mode
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [1:0] rst_s;
    logic [1:0] sck_s;
    logic [1:0] mosi_s;
    logic       sck_d;
    logic       rise;
    logic       fall;
    logic       pin_low;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rst_s  <= 2'h3;
            sck_s  <= 2'h0;
            mosi_s <= 2'h0;
            sck_d  <= 1'b0;
        end else begin
            rst_s  <= {rst_s[0], pin_rst_n};
            sck_s  <= {sck_s[0], sck};
            mosi_s <= {mosi_s[0], mosi};
            sck_d  <= sck_s[1];
        end
    end

    // edge detect needs clock phases over two main clocks
    assign rise    = sck_s[1] & ~sck_d;  // RULE6
    assign fall    = ~sck_s[1] & sck_d;
    assign pin_low = ~rst_s[1];

    // ****************************************
    // shifter
    // ****************************************
    logic [31:0] in_ff;
    logic [31:0] nxt_in;
    logic [4:0]  bit_ff;
    logic [7:0]  out_ff;
    logic        miso_ff;
    logic        en_ff;
    logic [7:0]  rd_val;

    assign nxt_in = {in_ff[30:0], mosi_s[1]};

    always_ff @(posedge clk) begin
        if (!rst_n || !pin_low) begin
            bit_ff <= '0;  // RULE18
            in_ff  <= '0;
        end else if (rise) begin
            in_ff  <= nxt_in;  // RULE7
            bit_ff <= bit_ff + 5'h01;  // RULE28
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || !pin_low) begin
            out_ff  <= '0;
            miso_ff <= 1'b0;
        end else if (rise && bit_ff[2:0] == `SISP_BYTE_END) begin
            // byte four carries read data; a missed enable echoes zero so the host resyncs
            out_ff <= (bit_ff == `SISP_BIT_B3) ? rd_val :
                      (bit_ff != `SISP_BIT_B2 ||
                       nxt_in[15:0] == {`SISP_OP_ENA, `SISP_B2_ENA}) ? nxt_in[7:0] :
                      `SISP_ZERO;  // RULE11
        end else if (fall) begin
            miso_ff <= out_ff[7];  // RULE8
            out_ff  <= {out_ff[6:0], 1'b0};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || !pin_low) begin
            en_ff <= 1'b0;  // RULE1 RULE18
        end else if (rise && bit_ff == `SISP_BIT_B2 &&
                     nxt_in[15:8] == `SISP_OP_ENA &&
                     nxt_in[7:0] == `SISP_B2_ENA) begin
            en_ff <= 1'b1;  // RULE24
        end
    end

    assign miso      = miso_ff;
    assign prog_mode = en_ff;

    // ****************************************
    // instruction queue
    // ****************************************
    sisp_state_e st_ff;
    sisp_instr_s q_in;
    sisp_instr_s q_out;
    logic        q_valid;
    logic        q_rdy_in;
    logic        q_ovalid;
    logic        q_pop;

    // a full queue drops the frame; the programmer polls anyway
    assign q_valid = rise && bit_ff == `SISP_BIT_LAST && en_ff;  // RULE2
    assign q_in    = '{stale: (st_ff != ST_IDLE), op: nxt_in[31:24],
                       b2: nxt_in[23:16], b3: nxt_in[15:8], b4: nxt_in[7:0]};
    assign q_pop   = (st_ff == ST_IDLE);

    sisp_fifo #(
        .W ($bits(sisp_instr_s)),
        .D (`SISP_FIFO_D)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (q_valid),
        .in_ready  (q_rdy_in),
        .in_data   (q_in),
        .out_valid (q_ovalid),
        .out_ready (q_pop),
        .out_data  (q_out)
    );

    // ****************************************
    // executor
    // ****************************************
    logic [23:0] tmr_ff;
    logic        wee_ff;
    logic        whi_ff;
    logic [11:0] wad_ff;
    logic [7:0]  wdat_ff;
    logic [11:0] clr_ff;
    logic [1:0]  lock_ff;
    logic        take;
    logic        is_er;
    logic        is_lk;
    logic        is_fw;
    logic        is_ew;
    logic        ee_half;
    logic        done;

    // instructions that arrived while busy are discarded
    assign take  = q_ovalid && q_pop && !q_out.stale && en_ff;  // RULE29 RULE2
    assign is_er = q_out.op == `SISP_OP_ENA && q_out.b2[7:5] == `SISP_ER_TOP;  // RULE25
    assign is_lk = q_out.op == `SISP_OP_ENA && q_out.b2[7:3] == `SISP_LK_TOP;
    assign is_fw = q_out.op[7:4] == `SISP_FL_WR && q_out.op[2:0] == `SISP_FL_LOW;
    assign is_ew = q_out.op == `SISP_OP_EEW;  // RULE26
    assign ee_half = tmr_ff > 24'(WR_CYC / 2);
    assign done  = (tmr_ff == 24'h000001);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff  <= ST_IDLE;
            tmr_ff <= '0;
        end else begin
            case (st_ff)
                ST_IDLE: begin
                    if (take && is_er) begin
                        st_ff  <= ST_ERASE;
                        tmr_ff <= 24'(ER_CYC);  // RULE29
                    end else if (take && (is_fw || is_ew)) begin
                        st_ff  <= ST_WRITE;
                        tmr_ff <= 24'(WR_CYC);  // RULE29
                    end
                end
                ST_WRITE, ST_ERASE: begin
                    tmr_ff <= tmr_ff - 24'h000001;
                    if (done) begin
                        st_ff <= ST_IDLE;
                    end
                end
                default: begin
                    st_ff <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wee_ff  <= 1'b0;
            whi_ff  <= 1'b0;
            wad_ff  <= '0;
            wdat_ff <= '0;
        end else if (st_ff == ST_IDLE && take && (is_fw || is_ew)) begin
            wee_ff  <= is_ew;
            whi_ff  <= q_out.op[3];
            // flash word address vs eeprom byte address
            wad_ff  <= is_ew ? {3'h0, q_out.b2[0], q_out.b3}
                             : {q_out.b2[3:0], q_out.b3};  // RULE5
            wdat_ff <= q_out.b4;  // RULE15
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clr_ff <= '0;
        end else if (st_ff == ST_ERASE) begin
            clr_ff <= clr_ff + 12'h001;
        end else begin
            clr_ff <= '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lock_ff <= 2'h3;
        end else if (st_ff == ST_ERASE && done) begin
            lock_ff <= 2'h3;
        end else if (st_ff == ST_IDLE && take && is_lk) begin
            // lock bits only program; erase clears them
            lock_ff <= lock_ff & {q_out.b2[1], q_out.b2[2]};
        end
    end

    // ****************************************
    // arrays
    // ****************************************
    logic [7:0] fl_lo [`SISP_FL_WORDS];
    logic [7:0] fl_hi [`SISP_FL_WORDS];
    logic [7:0] ee    [`SISP_EE_BYTES];

    // erase walks one location a cycle; the erase wait must be at least 4096
    always_ff @(posedge clk) begin
        if (st_ff == ST_ERASE) begin
            fl_lo[clr_ff]      <= `SISP_ONES;  // RULE4
            fl_hi[clr_ff]      <= `SISP_ONES;
            ee[clr_ff[8:0]]    <= `SISP_ONES;
        end else if (st_ff == ST_WRITE && wee_ff &&
                     tmr_ff == 24'(WR_CYC / 2)) begin
            ee[wad_ff[8:0]]    <= `SISP_ONES;  // RULE3
        end else if (st_ff == ST_WRITE && done) begin
            if (wee_ff) begin
                ee[wad_ff[8:0]] <= wdat_ff;  // RULE15
            end else if (whi_ff) begin
                fl_hi[wad_ff]   <= wdat_ff;
            end else begin
                fl_lo[wad_ff]   <= wdat_ff;
            end
        end
    end

    // ****************************************
    // read decode on byte three
    // ****************************************
    logic [7:0]  r_op;
    logic [11:0] r_fa;
    logic [8:0]  r_ea;
    logic        busy_w;

    assign r_op   = nxt_in[23:16];
    assign r_fa   = {nxt_in[11:8], nxt_in[7:0]};
    assign r_ea   = {nxt_in[8], nxt_in[7:0]};
    assign busy_w = (st_ff == ST_WRITE);

    always_comb begin
        rd_val = `SISP_ZERO;
        if (r_op == `SISP_OP_EER) begin
            if (busy_w && wee_ff && wad_ff[8:0] == r_ea) begin
                rd_val = ee_half ? `SISP_ZERO : `SISP_ONES;  // RULE19
            end else begin
                rd_val = ee[r_ea];  // RULE17
            end
        end else if (r_op[7:4] == `SISP_FL_RD && r_op[2:0] == `SISP_FL_LOW) begin
            if (busy_w && !wee_ff && wad_ff == r_fa && whi_ff == r_op[3]) begin
                rd_val = `SISP_ONES;  // RULE21
            end else begin
                rd_val = r_op[3] ? fl_hi[r_fa] : fl_lo[r_fa];  // RULE17
            end
        end else if (r_op == `SISP_OP_FUSE) begin
            rd_val = {lock_ff, SPIEN_P, `SISP_RSV_HI, FSTRT_P};  // RULE27
        end else if (r_op == `SISP_OP_SIG && lock_ff != 2'h0) begin
            case (nxt_in[1:0])
                2'h0:    rd_val = SIG_BYTES[23:16];
                2'h1:    rd_val = SIG_BYTES[15:8];
                2'h2:    rd_val = SIG_BYTES[7:0];
                default: rd_val = `SISP_ZERO;
            endcase
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_no_run_wo_en;
        @(posedge clk) disable iff (!rst_n)
        (st_ff == ST_IDLE && st_ff != $past(st_ff)) or
        (st_ff == ST_IDLE) or $past(en_ff) or $past(st_ff) != ST_IDLE;
    endproperty
    a_no_run_wo_en: assert property (p_no_run_wo_en)  // RULE2
        else $error("write or erase started without enable");

    property p_leave;
        @(posedge clk) disable iff (!rst_n)
        !pin_low |=> !en_ff && bit_ff == 5'h00;
    endproperty
    a_leave: assert property (p_leave)  // RULE18
        else $error("programming mode kept with reset high");

    property p_echo;
        @(posedge clk) disable iff (!rst_n)
        (rise && pin_low && bit_ff == `SISP_BIT_B2) |=>
        out_ff == ((in_ff[15:0] == {`SISP_OP_ENA, `SISP_B2_ENA}) ? in_ff[7:0] : `SISP_ZERO);
    endproperty
    a_echo: assert property (p_echo)  // RULE11
        else $error("second byte not loaded for echo");

    property p_fall_out;
        @(posedge clk) disable iff (!rst_n)
        (fall && pin_low) |=> miso_ff == $past(out_ff[7]);
    endproperty
    a_fall_out: assert property (p_fall_out)  // RULE8
        else $error("output bit not shifted on falling edge");

    property p_rise_in;
        @(posedge clk) disable iff (!rst_n)
        (rise && pin_low) |=> in_ff[0] == $past(mosi_s[1]) && in_ff[31:1] == $past(in_ff[30:0]);
    endproperty
    a_rise_in: assert property (p_rise_in)  // RULE7
        else $error("input bit not sampled on rising edge");

    property p_frame;
        @(posedge clk) disable iff (!rst_n)
        (rise && pin_low && bit_ff == `SISP_BIT_LAST) |=> bit_ff == 5'h00;
    endproperty
    a_frame: assert property (p_frame)  // RULE28
        else $error("frame is not 32 bits");

    property p_busy_hold;
        @(posedge clk) disable iff (!rst_n)
        (busy_w && !done) |=> busy_w && $stable(wad_ff) && $stable(wdat_ff);
    endproperty
    a_busy_hold: assert property (p_busy_hold)  // RULE29
        else $error("busy write disturbed");

    property p_write_len;
        @(posedge clk) disable iff (!rst_n)
        (busy_w && !$past(busy_w)) |-> tmr_ff == 24'(WR_CYC);
    endproperty
    a_write_len: assert property (p_write_len)  // RULE29
        else $error("write wait not loaded");

    property p_poll_fl;
        @(posedge clk) disable iff (!rst_n)
        (rise && pin_low && bit_ff == `SISP_BIT_B3 && busy_w && !wee_ff &&
         r_op[7:4] == `SISP_FL_RD && r_op[2:0] == `SISP_FL_LOW &&
         r_fa == wad_ff && r_op[3] == whi_ff) |=> out_ff == `SISP_ONES;
    endproperty
    a_poll_fl: assert property (p_poll_fl)  // RULE21
        else $error("flash poll value wrong");

    property p_poll_ee;
        @(posedge clk) disable iff (!rst_n)
        (rise && pin_low && bit_ff == `SISP_BIT_B3 && busy_w && wee_ff &&
         r_op == `SISP_OP_EER && r_ea == wad_ff[8:0])
        |=> out_ff == ($past(ee_half) ? `SISP_ZERO : `SISP_ONES);
    endproperty
    a_poll_ee: assert property (p_poll_ee)  // RULE19
        else $error("eeprom poll value wrong");
endmodule

// *** sisp_cfg.svh ***
`ifndef SISP_CFG_SVH
`define SISP_CFG_SVH

// ****************************************
// instruction codes
// ****************************************
`define SISP_OP_ENA   8'hAC
`define SISP_B2_ENA   8'h53
`define SISP_OP_EEW   8'hC0
`define SISP_OP_EER   8'hA0
`define SISP_OP_FUSE  8'h58
`define SISP_OP_SIG   8'h30
`define SISP_FL_RD    4'h2
`define SISP_FL_WR    4'h4
`define SISP_FL_LOW   3'h0
`define SISP_ER_TOP   3'h4
`define SISP_LK_TOP   5'h1F

// ****************************************
// poll values and fills
// ****************************************
`define SISP_ONES     8'hFF
`define SISP_ZERO     8'h00
`define SISP_RSV_HI   4'hF

// ****************************************
// frame bit positions
// ****************************************
`define SISP_BIT_B2   5'h0F
`define SISP_BIT_B3   5'h17
`define SISP_BIT_LAST 5'h1F
`define SISP_BYTE_END 3'h7

// ****************************************
// sizes and timing
// ****************************************
`define SISP_FL_WORDS 4096
`define SISP_EE_BYTES 512
`define SISP_FIFO_D   32
`define SISP_CLK_MHZ  100
`define SISP_WR_MS    4
`define SISP_ER_MS    8
`define SISP_US_MS    1000

`endif

// *** sisp_pkg.sv ***
package sisp_pkg;

    typedef struct packed {
        logic       stale;
        logic [7:0] op;
        logic [7:0] b2;
        logic [7:0] b3;
        logic [7:0] b4;
    } sisp_instr_s;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_WRITE = 3'b010,
        ST_ERASE = 3'b100
    } sisp_state_e;

endpackage

// *** sisp_fifo.sv ***
`timescale 1ns/100ps
module sisp_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_ff;
    logic [AW-1:0] rp_ff;
    logic [AW:0]   cnt_ff;
    logic          push;
    logic          pop;

    assign in_ready  = (cnt_ff != (AW+1)'(D));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem[rp_ff];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_ff] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wp_ff <= (wp_ff == AW'(D-1)) ? '0 : wp_ff + AW'(1);
            end
            if (pop) begin
                rp_ff <= (rp_ff == AW'(D-1)) ? '0 : rp_ff + AW'(1);
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// *** sisp_prog_model.sv ***
`timescale 1ns/100ps
// ****************************************
// programmer on the far side of the link
// ****************************************
module sisp_prog_model #(
    parameter real HALF = 62.5
) (
    output logic      sck,
    input  wire logic miso,
    output logic      mosi,
    output logic      pin_rst_n
);
    initial begin
        sck       = 1'b0;
        mosi      = 1'b0;
        pin_rst_n = 1'b0;
    end

    // clock stands low between frames, phases far above two main clocks
    task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
        for (int i = 31; i >= 0; i--) begin
            mosi = tx[i];
            #HALF;
            rx[i] = miso;
            sck = 1'b1;
            #HALF;
            sck = 1'b0;
        end
        #HALF;
        // released line must not keep showing the last bit
        mosi = ~mosi;
    endtask

    // one extra high pulse of the serial clock, shifts the framing by a bit
    task automatic pulse();
        sck = 1'b1;
        #HALF;
        sck = 1'b0;
        #HALF;
    endtask

    task automatic set_pin(input logic v);
        pin_rst_n = v;
    endtask
endmodule

// *** serial_isp_download_tb.sv ***
`timescale 1ns/100ps
module serial_isp_download_tb;
    localparam int WR = 2000;
    localparam int ER = 5000;
    // arbitrary signature value, mirrored into the design
    localparam logic [23:0] SIG = 24'h5A3C69;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sck;
    logic mosi;
    logic miso;
    logic pin_rst_n;
    logic prog_mode;
    logic [31:0] rx;
    logic [7:0] d;
    int miscompares = 0;
    int compares = 0;

    always #5 clk = ~clk;

    sisp_top #(.WR_CYC(WR), .ER_CYC(ER), .SIG_BYTES(SIG)) dut (
        .clk(clk), .rst_n(rst_n), .pin_rst_n(pin_rst_n), .sck(sck),
        .mosi(mosi), .miso(miso), .prog_mode(prog_mode));

    sisp_prog_model prog (.sck(sck), .miso(miso), .mosi(mosi), .pin_rst_n(pin_rst_n));

    // ****************************************
    // shared helpers
    // ****************************************
    task automatic print_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic chk_mode(input logic exp);
        int n;
        n = 0;
        while (prog_mode !== exp && n < 50) begin
            @(negedge clk);
            n++;
        end
        chk("prog_mode", {7'h00, exp}, {7'h00, prog_mode});
        if (n >= 50) begin
            print_verdict();
        end
    endtask

    task automatic rd(input logic [23:0] cmd, output logic [7:0] v);
        logic [31:0] r;
        prog.frame({cmd, 8'h00}, r);
        v = r[7:0];
    endtask

    task automatic enable();
        prog.frame(32'hAC53_0000, rx);
        chk("echo", 8'h53, rx[15:8]);
        chk_mode(1'b1);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic sc_locked();
        prog.set_pin(1'b1);
        wt(5);
        prog.frame(32'hAC53_0000, rx);
        chk_mode(1'b0);
        prog.set_pin(1'b0);
        wt(5);
        enable();
    endtask

    task automatic sc_erase();
        prog.frame(32'hAC80_0000, rx);
        wt(ER + 100);
        prog.set_pin(1'b1);
        wt(5);
        chk_mode(1'b0);
        prog.set_pin(1'b0);
        wt(20);
        // write before enable must be refused
        prog.frame(32'hC000_0512, rx);
        enable();
        rd(24'hA0_0005, d);
        chk("ee 005", 8'hFF, d);
        rd(24'h20_0000, d);
        chk("fl 000 lo", 8'hFF, d);
        rd(24'h28_0FFF, d);
        chk("fl FFF hi", 8'hFF, d);
        rd(24'hA0_01FF, d);
        chk("ee 1FF", 8'hFF, d);
        rd(24'h58_0000, d);
        chk("fuse", 8'hDF, d);
    endtask

    task automatic sc_ee_poll();
        prog.frame(32'hC001_FF3C, rx);
        rd(24'hA0_01FF, d);
        chk("ee poll erasing", 8'h00, d);
        // second write lands while busy and is dropped
        prog.frame(32'hC001_FF77, rx);
        wt(300);
        rd(24'hA0_01FF, d);
        chk("ee poll erased", 8'hFF, d);
        wt(600);
        rd(24'hA0_01FF, d);
        chk("ee new value", 8'h3C, d);
        // zero equals a poll value, so only the full wait is safe
        prog.frame(32'hC000_0500, rx);
        wt(WR + 50);
        rd(24'hA0_0005, d);
        chk("ee 005 zero", 8'h00, d);
    endtask

    task automatic sc_flash_poll();
        prog.frame(32'h4801_23A5, rx);
        rd(24'h28_0123, d);
        chk("fl poll", 8'hFF, d);
        wt(WR + 50);
        rd(24'h28_0123, d);
        chk("fl 123 hi", 8'hA5, d);
        rd(24'h20_0123, d);
        chk("fl 123 lo", 8'hFF, d);
        rd(24'hA0_0123, d);
        chk("ee 123", 8'hFF, d);
        // all ones cannot be polled on flash
        prog.frame(32'h4001_24FF, rx);
        wt(WR + 50);
        rd(24'h20_0124, d);
        chk("fl 124 lo", 8'hFF, d);
    endtask

    task automatic sc_resync();
        int tries;
        prog.set_pin(1'b1);
        wt(5);
        prog.set_pin(1'b0);
        wt(5);
        // stray pulses leave the device framing one bit off
        repeat (31) prog.pulse();
        tries = 0;
        rx = '0;
        while (rx[15:8] !== 8'h53 && tries < 32) begin
            if (tries > 0) begin
                prog.pulse();
            end
            prog.frame(32'hAC53_0000, rx);
            tries++;
        end
        chk("enable tries", 8'h02, 8'(tries));
        chk_mode(1'b1);
        rd(24'h30_0000, d);
        chk("sig 0", SIG[23:16], d);
        prog.frame(32'hACF9_0000, rx);
        rd(24'h58_0000, d);
        chk("fuse locked", 8'h1F, d);
        rd(24'h30_0000, d);
        chk("sig locked", 8'h00, d);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        wt(6);
        rst_n <= 1'b1;
        // start-up wait shortened to keep the run small
        wt(100);
        sc_locked();
        sc_erase();
        sc_ee_poll();
        sc_flash_poll();
        sc_resync();
        print_verdict();
    end

    initial begin
        wt(60000);
        miscompares++;
        $display("[FAIL] run limit expected end seen hang");
        print_verdict();
    end
endmodule
